/* hw/sig_pkg.sv */
// package: constants for the safety interlock output gate
package sig_pkg;
  // register word addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h4;
  localparam logic [3:0] ADDR_TRIP = 4'h5;
  localparam logic [3:0] ADDR_PULSE = 4'h6;
  // control fields
  localparam int CTRL_ON_REQ = 0;
  localparam int CTRL_OFF_REQ = 1;
  localparam int CTRL_PULSE_GO = 2;
  // status fields
  localparam int ST_OUT_ON = 0;
  localparam int ST_LOOP_OK = 1;
  localparam int ST_KEY_OK = 2;
  localparam int ST_TRIP = 3;
  localparam int ST_LAMP_GREEN = 4;
  localparam int ST_PULSE_BUSY = 5;
  // interrupt event bits
  localparam int IRQ_W = 4;
  localparam int EV_TRIP = 0;
  localparam int EV_OUT_ON = 1;
  localparam int EV_OUT_OFF = 2;
  localparam int EV_REFUSED = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  // pulse timing
  localparam int PULSE_W = 16;
  localparam logic [PULSE_W-1:0] PULSE_WIDTH_RESET = 16'h0032;
  // fixed latency of the sync strobe ahead of the current pulse, given in ns and rounded up to cycles
  localparam int SYNC_LEAD_NS = 40;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SYNC_LEAD_CYC = (SYNC_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEAD_W = 3;
  // lamp colour codes
  typedef enum logic [1:0] {
    SIG_LAMP_OFF,
    SIG_LAMP_BLUE,
    SIG_LAMP_GREEN
  } sig_lamp_e;
endpackage : sig_pkg

/* hw/sig_pulse_if.sv */
// interface: pulse request and strobe carrier between the gate and the pulse timer
interface sig_pulse_if;
  logic go;
  logic enable;
  logic [sig_pkg::PULSE_W-1:0] width;
  logic current;
  logic sync;
  logic busy;
  modport gate (output go, output enable, output width, input current, input sync, input busy);
  modport timer (input go, input enable, input width, output current, output sync, output busy);
endinterface : sig_pulse_if

/* hw/sig_irq.sv */
// module: sticky interrupt status with enable and write-to-clear
module sig_irq (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // events and software access
  input wire logic [sig_pkg::IRQ_W-1:0] i_event,
  input wire logic [sig_pkg::IRQ_W-1:0] i_clear,
  input wire logic [sig_pkg::IRQ_W-1:0] i_enable,
  // results
  output logic [sig_pkg::IRQ_W-1:0] o_status,
  output logic o_irq
);
  typedef struct packed {
    logic [sig_pkg::IRQ_W-1:0] status;
  } sig_irq_s;

  sig_irq_s st;
  sig_irq_s next_st;

  always_comb begin
    next_st = st;
    // a new event wins over a clear in the same cycle
    next_st.status = (st.status & ~i_clear) | i_event;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '{status: sig_pkg::IRQ_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign o_status = st.status;
  assign o_irq = |(st.status & i_enable);
endmodule : sig_irq

/* hw/sig_pulse_timer.sv */
// module: laser current pulse timer with an early sync strobe of matching width for widths of 3 or more
module sig_pulse_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // pulse port
  sig_pulse_if.timer pif
);
  typedef enum logic [1:0] {
    SIG_PT_IDLE,
    SIG_PT_LEAD,
    SIG_PT_PULSE,
    SIG_PT_TAIL
  } sig_pt_e;

  typedef struct packed {
    sig_pt_e state;
    logic [sig_pkg::PULSE_W-1:0] cnt;
    logic [sig_pkg::LEAD_W-1:0] lead;
    logic sync;
    logic current;
  } sig_pt_s;

  sig_pt_s st;
  sig_pt_s next_st;

  always_comb begin
    next_st = st;
    case (st.state)
      SIG_PT_IDLE: begin
        if (pif.go && pif.enable && pif.width != '0) begin
          next_st.state = SIG_PT_LEAD;
          next_st.sync = 1'b1;
          next_st.cnt = pif.width;
          next_st.lead = sig_pkg::LEAD_W'(sig_pkg::SYNC_LEAD_CYC);
        end
      end
      // sync rises first; current follows after the fixed lead
      SIG_PT_LEAD: begin
        next_st.lead = st.lead - 1'b1;
        if (st.lead == 1) begin
          next_st.state = SIG_PT_PULSE;
          next_st.current = 1'b1;
        end
      end
      // sync falls the same lead ahead of the current, so widths match for widths of 3 or more
      SIG_PT_PULSE: begin
        next_st.cnt = st.cnt - 1'b1;
        if (st.cnt == 16'(sig_pkg::SYNC_LEAD_CYC) + 16'h0001) begin
          next_st.sync = 1'b0;
        end
        if (st.cnt == 16'h0001) begin
          next_st.state = SIG_PT_IDLE;
          next_st.current = 1'b0;
          next_st.sync = 1'b0;
        end
      end
      SIG_PT_TAIL: begin
        next_st.state = SIG_PT_IDLE;
      end
      default: begin
        next_st.state = SIG_PT_IDLE;
      end
    endcase
    // an interlock drop kills the pulse at once
    if (!pif.enable) begin
      next_st.state = SIG_PT_IDLE;
      next_st.current = 1'b0;
      next_st.sync = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '{state: SIG_PT_IDLE, cnt: '0, lead: '0, sync: 1'b0, current: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pif.current = st.current;
  assign pif.sync = st.sync;
  assign pif.busy = (st.state != SIG_PT_IDLE);
endmodule : sig_pulse_timer

/* hw/sig_gate.sv */
// module: safety interlock output gate, top level
module sig_gate (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // interlock inputs, high when closed
  input wire logic i_loop_closed,
  input wire logic i_key_enabled,
  // operator toggle button, one-cycle press pulse
  input wire logic i_toggle_press,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // source outputs
  output logic [2:0] o_source_en,
  output logic o_current_pulse,
  output logic o_pulse_sync,
  // lamps
  output sig_pkg::sig_lamp_e o_safety_lamp,
  output sig_pkg::sig_lamp_e o_armed_lamp,
  output sig_pkg::sig_lamp_e o_output_lamp,
  // status
  output logic o_trip,
  output logic o_irq
);
  typedef struct packed {
    logic out_on;
    logic trip_d;
    logic [sig_pkg::IRQ_W-1:0] irq_en;
    logic [sig_pkg::PULSE_W-1:0] width;
    logic [31:0] rdata;
  } sig_gate_s;

  sig_gate_s st;
  sig_gate_s next_st;

  sig_pulse_if pif ();

  logic permit;
  logic trip;
  logic on_req;
  logic off_req;
  logic [sig_pkg::IRQ_W-1:0] events;
  logic [sig_pkg::IRQ_W-1:0] irq_clear;
  logic [sig_pkg::IRQ_W-1:0] irq_status;
  logic [31:0] status_word;

  // both interlocks must be closed, checked every cycle
  assign permit = i_loop_closed && i_key_enabled;
  assign trip = !permit;

  assign on_req = (i_wr && i_addr == sig_pkg::ADDR_CTRL && i_wdata[sig_pkg::CTRL_ON_REQ])
                  || (i_toggle_press && !st.out_on);
  assign off_req = (i_wr && i_addr == sig_pkg::ADDR_CTRL && i_wdata[sig_pkg::CTRL_OFF_REQ])
                   || (i_toggle_press && st.out_on);

  assign irq_clear = (i_wr && i_addr == sig_pkg::ADDR_IRQ_CLR)
                     ? i_wdata[sig_pkg::IRQ_W-1:0] : '0;

  always_comb begin
    status_word = '0;
    status_word[sig_pkg::ST_OUT_ON] = st.out_on;
    status_word[sig_pkg::ST_LOOP_OK] = i_loop_closed;
    status_word[sig_pkg::ST_KEY_OK] = i_key_enabled;
    status_word[sig_pkg::ST_TRIP] = trip;
    status_word[sig_pkg::ST_LAMP_GREEN] = permit;
    status_word[sig_pkg::ST_PULSE_BUSY] = pif.busy;
  end

  always_comb begin
    events = '0;
    events[sig_pkg::EV_TRIP] = trip && !st.trip_d;
    events[sig_pkg::EV_OUT_ON] = !st.out_on && next_st.out_on;
    events[sig_pkg::EV_OUT_OFF] = st.out_on && !next_st.out_on;
    events[sig_pkg::EV_REFUSED] = on_req && !permit && !st.out_on;
  end

  always_comb begin
    next_st = st;
    next_st.trip_d = trip;
    // output state: turn-on only with permit, drop at once on trip
    if (!permit) begin
      next_st.out_on = 1'b0;
    end else if (off_req) begin
      next_st.out_on = 1'b0;
    end else if (on_req) begin
      next_st.out_on = 1'b1;
    end
    if (i_wr && i_addr == sig_pkg::ADDR_IRQ_EN) begin
      next_st.irq_en = i_wdata[sig_pkg::IRQ_W-1:0];
    end
    if (i_wr && i_addr == sig_pkg::ADDR_PULSE) begin
      next_st.width = i_wdata[sig_pkg::PULSE_W-1:0];
    end
    next_st.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        sig_pkg::ADDR_STATUS: next_st.rdata = status_word;
        sig_pkg::ADDR_IRQ_STAT: next_st.rdata = {28'h000_0000, irq_status};
        sig_pkg::ADDR_IRQ_EN: next_st.rdata = {28'h000_0000, st.irq_en};
        sig_pkg::ADDR_TRIP: next_st.rdata = {31'h0000_0000, trip};
        sig_pkg::ADDR_PULSE: next_st.rdata = {16'h0000, st.width};
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '{out_on: 1'b0, trip_d: 1'b0, irq_en: sig_pkg::IRQ_RESET,
              width: sig_pkg::PULSE_WIDTH_RESET, rdata: 32'h0000_0000};
    end else begin
      st <= next_st;
    end
  end

  // pulses are launched by software only while outputs are on and permitted
  assign pif.go = i_wr && i_addr == sig_pkg::ADDR_CTRL && i_wdata[sig_pkg::CTRL_PULSE_GO];
  assign pif.enable = st.out_on && permit;
  assign pif.width = st.width;

  sig_pulse_timer u_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .pif(pif.timer)
  );

  sig_irq u_irq (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_event(events),
    .i_clear(irq_clear),
    .i_enable(st.irq_en),
    .o_status(irq_status),
    .o_irq(o_irq)
  );

  // outputs gated combinationally too, so an open loop cuts them in the same cycle
  assign o_source_en = {3{st.out_on && permit}};
  assign o_current_pulse = pif.current && permit;
  assign o_pulse_sync = pif.sync && permit;
  assign o_safety_lamp = permit ? sig_pkg::SIG_LAMP_GREEN : sig_pkg::SIG_LAMP_BLUE;
  assign o_armed_lamp = (st.out_on && permit) ? sig_pkg::SIG_LAMP_BLUE
                        : sig_pkg::SIG_LAMP_OFF;
  assign o_output_lamp = (st.out_on && permit) ? sig_pkg::SIG_LAMP_BLUE
                         : sig_pkg::SIG_LAMP_OFF;
  assign o_trip = trip;
  assign o_rdata = st.rdata;
endmodule : sig_gate

/* verification/sig_gate_props.sv */
// checker: port assertions for the interlock output gate
module sig_gate_props (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // inputs
  input wire logic i_loop_closed,
  input wire logic i_key_enabled,
  input wire logic i_toggle_press,
  input wire logic [3:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  // outputs
  input wire logic [31:0] o_rdata,
  input wire logic [2:0] o_source_en,
  input wire logic o_current_pulse,
  input wire logic o_pulse_sync,
  input wire sig_pkg::sig_lamp_e o_safety_lamp,
  input wire sig_pkg::sig_lamp_e o_armed_lamp,
  input wire sig_pkg::sig_lamp_e o_output_lamp,
  input wire logic o_trip
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam sig_pkg::sig_lamp_e OF = sig_pkg::SIG_LAMP_OFF;
  localparam sig_pkg::sig_lamp_e BL = sig_pkg::SIG_LAMP_BLUE;
  logic ok;
  logic armed;
  assign ok = i_loop_closed & i_key_enabled;
  // an off request in the first of the two lead cycles legally cancels the pulse
  assign armed = ok && o_source_en == 3'h7;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_sync_rise;
    $rose(o_pulse_sync);
  endsequence
  sequence s_held;
    armed [*3];
  endsequence
  property p_permit; |o_source_en |-> ok; endproperty
  property p_loop;
    !i_loop_closed |-> o_source_en == 3'h0 && !o_current_pulse && !o_pulse_sync;
  endproperty
  property p_blue;
    i_loop_closed && !i_key_enabled |->
      o_safety_lamp == BL && o_armed_lamp == OF && o_output_lamp == OF;
  endproperty
  property p_green;
    ok && o_source_en == 3'h0 |->
      o_safety_lamp == sig_pkg::SIG_LAMP_GREEN && o_armed_lamp == OF && o_output_lamp == OF;
  endproperty
  property p_on;
    ok && i_toggle_press && o_source_en == 3'h0 && !i_wr |=>
      !ok || (o_source_en == 3'h7 && o_armed_lamp == BL && o_output_lamp == BL);
  endproperty
  property p_trip; o_trip == !ok; endproperty
  property p_lead; s_sync_rise ##0 s_held |-> o_current_pulse; endproperty
  property p_lag; $rose(o_current_pulse) |-> $past(o_pulse_sync, 2); endproperty
  property p_stay; !ok |=> o_source_en == 3'h0; endproperty
  property p_query;
    i_rd && i_addr == sig_pkg::ADDR_TRIP |=> o_rdata == {31'h0, $past(o_trip)};
  endproperty
  a_permit: assert property (p_permit) else $error("source on while not permitted");
  a_loop: assert property (p_loop) else $error("output active with loop open");
  a_blue: assert property (p_blue) else $error("wrong lamps with key disabled");
  a_green: assert property (p_green) else $error("wrong lamps while armed off");
  a_on: assert property (p_on) else $error("press did not turn outputs on");
  a_trip: assert property (p_trip) else $error("trip flag wrong");
  a_lead: assert property (p_lead) else $error("current not two after sync");
  a_lag: assert property (p_lag) else $error("current without leading sync");
  a_stay: assert property (p_stay) else $error("outputs back on after open");
  a_query: assert property (p_query) else $error("trip read wrong");
endmodule : sig_gate_props

bind sig_gate sig_gate_props u_sig_gate_props (.i_clk, .i_sys_rst, .i_loop_closed,
  .i_key_enabled, .i_toggle_press, .i_addr, .i_wr, .i_rd, .o_rdata, .o_source_en,
  .o_current_pulse, .o_pulse_sync, .o_safety_lamp, .o_armed_lamp, .o_output_lamp, .o_trip);

/* verification/sig_operator_model.sv */
// model: fixture lid switch, key switch and operator button
module sig_operator_model (
  // clock
  input wire logic i_clk,
  // bench commands
  input wire logic i_lid_shut,
  input wire logic i_key_on,
  input wire logic i_push,
  // switch lines toward the gate
  output logic o_loop_closed = 1'b0,
  output logic o_key_enabled = 1'b0,
  output logic o_toggle_press = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic held = 1'b0;
  // a held push gives one press pulse only
  always @(posedge i_clk) begin
    o_loop_closed <= i_lid_shut;
    o_key_enabled <= i_key_on;
    o_toggle_press <= i_push && !held;
    held <= i_push;
  end
endmodule : sig_operator_model

/* verification/sig_gate_tb.sv */
// testbench: interlock rows, switching, registers and pulse for the gate
module sig_gate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic lid; logic key; logic trip; sig_pkg::sig_lamp_e lamp;} sig_row_s;
  localparam sig_pkg::sig_lamp_e OF = sig_pkg::SIG_LAMP_OFF;
  localparam sig_pkg::sig_lamp_e BL = sig_pkg::SIG_LAMP_BLUE;
  localparam sig_pkg::sig_lamp_e GN = sig_pkg::SIG_LAMP_GREEN;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic lid = 1'b0, key = 1'b0, push = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic i_loop_closed, i_key_enabled, i_toggle_press, o_current_pulse, o_pulse_sync;
  logic o_trip, o_irq;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [31:0] o_rdata, d;
  logic [2:0] o_source_en;
  sig_pkg::sig_lamp_e o_safety_lamp, o_armed_lamp, o_output_lamp;
  int num_errors = 0, num_checks = 0, fs, fc, ns, nc;
  sig_row_s rows [4] = '{'{1'b0, 1'b0, 1'b1, BL}, '{1'b0, 1'b1, 1'b1, BL},
    '{1'b1, 1'b0, 1'b1, BL}, '{1'b1, 1'b1, 1'b0, GN}};
  initial forever #10 i_clk = ~i_clk;
  sig_operator_model u_sig_operator_model (.i_clk, .i_lid_shut(lid), .i_key_on(key),
    .i_push(push), .o_loop_closed(i_loop_closed), .o_key_enabled(i_key_enabled),
    .o_toggle_press(i_toggle_press));
  sig_gate u_sig_gate (.i_clk, .i_sys_rst, .i_loop_closed, .i_key_enabled, .i_toggle_press,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_source_en, .o_current_pulse, .o_pulse_sync,
    .o_safety_lamp, .o_armed_lamp, .o_output_lamp, .o_trip, .o_irq);
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task chk_lamp(input sig_pkg::sig_lamp_e g, input sig_pkg::sig_lamp_e e);
    chk(32'(g), 32'(e));
  endtask : chk_lamp
  task lamps(input sig_pkg::sig_lamp_e s, input sig_pkg::sig_lamp_e a);
    chk_lamp(o_safety_lamp, s);
    chk_lamp(o_armed_lamp, a);
    chk_lamp(o_output_lamp, a);
  endtask : lamps
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  // model adds one cycle before the gate sees a change
  task sw(input logic l, input logic k, input logic p, input int n);
    @(posedge i_clk);
    lid <= l;
    key <= k;
    push <= p;
    repeat (n) @(posedge i_clk);
    #1;
  endtask : sw
  task results;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(sig_pkg::ADDR_PULSE, d);
    chk(d, 32'h0000_0032);
    rd(sig_pkg::ADDR_IRQ_EN, d);
    chk(d, 32'h0000_0000);
    foreach (rows[i]) begin
      sw(rows[i].lid, rows[i].key, 1'b0, 2);
      chk(o_trip, rows[i].trip);
      lamps(rows[i].lamp, OF);
      chk(o_source_en, 3'h0);
      rd(sig_pkg::ADDR_TRIP, d);
      chk(d, rows[i].trip);
    end
    wr(sig_pkg::ADDR_IRQ_EN, 32'h0000_000f);
    sw(1'b1, 1'b1, 1'b1, 2);
    chk(o_source_en, 3'h7);
    lamps(GN, BL);
    rd(sig_pkg::ADDR_STATUS, d);
    chk(d, 32'h0000_0017);
    wr(sig_pkg::ADDR_PULSE, 32'h0000_0004);
    wr(sig_pkg::ADDR_CTRL, 32'h0000_0004);
    fs = -1;
    fc = -1;
    ns = 0;
    nc = 0;
    for (int i = 0; i < 20; i++) begin
      #1;
      if (o_pulse_sync === 1'b1) begin
        ns++;
        if (fs < 0) fs = i;
      end
      if (o_current_pulse === 1'b1) begin
        nc++;
        if (fc < 0) fc = i;
      end
      @(posedge i_clk);
    end
    chk(ns, 4);
    chk(nc, 4);
    chk(fc - fs, sig_pkg::SYNC_LEAD_CYC);
    sw(1'b1, 1'b0, 1'b0, 1);
    chk(o_source_en, 3'h0);
    lamps(BL, OF);
    sw(1'b1, 1'b1, 1'b0, 2);
    chk(o_source_en, 3'h0);
    lamps(GN, OF);
    rd(sig_pkg::ADDR_IRQ_STAT, d);
    chk(d, 32'h0000_0007);
    chk(o_irq, 1'b1);
    wr(sig_pkg::ADDR_IRQ_CLR, 32'h0000_0007);
    rd(sig_pkg::ADDR_IRQ_STAT, d);
    chk(d, 32'h0000_0000);
    chk(o_irq, 1'b0);
    sw(1'b0, 1'b1, 1'b1, 2);
    chk(o_source_en, 3'h0);
    rd(sig_pkg::ADDR_IRQ_STAT, d);
    chk(d, 32'h0000_0009);
    wr(sig_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    @(posedge i_clk);
    #1 chk(o_irq, 1'b0);
    rd(4'h7, d);
    chk(d, 32'h0000_0000);
    rd(sig_pkg::ADDR_CTRL, d);
    chk(d, 32'h0000_0000);
    sw(1'b1, 1'b1, 1'b0, 2);
    wr(sig_pkg::ADDR_CTRL, 32'h0000_0001);
    #1 chk(o_source_en, 3'h7);
    wr(sig_pkg::ADDR_CTRL, 32'h0000_0002);
    #1 chk(o_source_en, 3'h0);
    // reset in mid-run drops the outputs and restores the width
    wr(sig_pkg::ADDR_CTRL, 32'h0000_0001);
    wr(sig_pkg::ADDR_PULSE, 32'h0000_0009);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk(o_source_en, 3'h0);
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(sig_pkg::ADDR_PULSE, d);
    chk(d, 32'(sig_pkg::PULSE_WIDTH_RESET));
    results;
  end
endmodule : sig_gate_tb
